// file: hdl/irt_route_trim_regs.svh
`ifndef IRT_ROUTE_TRIM_REGS_SVH
`define IRT_ROUTE_TRIM_REGS_SVH

// register offsets on the serial register port
`define IRT_OFS_ROUTE      8'h2A
`define IRT_OFS_OFF_PRESS  8'h2B
`define IRT_OFS_OFF_TEMP   8'h2C
`define IRT_OFS_OFF_ALT    8'h2D

// reset values
`define IRT_RST_ROUTE      8'h00
`define IRT_RST_TRIM       8'h00
`define IRT_RST_UNMAPPED   8'h00

// routing bit positions
`define IRT_BIT_DATA_READY   7
`define IRT_BIT_FIFO         6
`define IRT_BIT_PRESS_WIN    5
`define IRT_BIT_TEMP_WIN     4
`define IRT_BIT_PRESS_THR    3
`define IRT_BIT_TEMP_THR     2
`define IRT_BIT_PRESS_CHG    1
`define IRT_BIT_TEMP_CHG     0

// number of interrupt sources and register width
`define IRT_NUM_SRC        8
`define IRT_REG_W          8

// compensated output widths and trim scaling (left shift of trim LSB)
`define IRT_PRESS_W        20
`define IRT_TEMP_W         12
`define IRT_ALT_W          20
`define IRT_PRESS_SHIFT    4
`define IRT_TEMP_SHIFT     0
`define IRT_ALT_SHIFT      4

`endif

// file: hdl/irt_pkg.sv
`include "irt_route_trim_regs.svh"

package irt_pkg;

   typedef logic [`IRT_NUM_SRC-1:0] irt_src_vec_t;

   typedef struct packed {
      logic [`IRT_REG_W-1:0]   route;
      logic [`IRT_REG_W-1:0]   off_press;
      logic [`IRT_REG_W-1:0]   off_temp;
      logic [`IRT_REG_W-1:0]   off_alt;
      logic [`IRT_REG_W-1:0]   rdata;
      logic                    pin_first;
      logic                    pin_second;
      logic [`IRT_PRESS_W-1:0] press;
      logic [`IRT_TEMP_W-1:0]  temp;
      logic [`IRT_ALT_W-1:0]   alt;
   } irt_state_t;

endpackage : irt_pkg

// file: hdl/irt_pin_if.sv
`timescale 1ns/1ps
`default_nettype none

interface irt_pin_if;
   irt_pkg::irt_src_vec_t src;
   irt_pkg::irt_src_vec_t enable;
   irt_pkg::irt_src_vec_t route;
   logic                  polarity;
   logic                  level;

   modport core  (output src, output enable, output route, output polarity, input level);
   modport drive (input src, input enable, input route, input polarity, output level);
endinterface : irt_pin_if

`default_nettype wire

// file: hdl/irt_pin_drive.sv
`timescale 1ns/1ps
`default_nettype none

// next level of one interrupt pin from its routed, enabled sources
module irt_pin_drive #(
   parameter bit FIRST_PIN = 1'b1
) (
   irt_pin_if.drive pin
);
   irt_pkg::irt_src_vec_t routed;
   logic                  active;

   // route bit 1 selects the first pin, 0 the second
   assign routed = FIRST_PIN ? pin.route : ~pin.route;
   // disabled sources are masked before the or
   assign active = |(pin.src & pin.enable & routed);
   // polarity 1 asserts high, 0 asserts low
   assign pin.level = pin.polarity ? active : ~active;
endmodule : irt_pin_drive

`default_nettype wire

// file: hdl/irt_route_trim.sv
// Contract
// - one routing bit per source chooses which interrupt pin it drives.
// - routing bit 0 sends source to second pin, 1 to first pin.
// - bits 7..0: ready, fifo, p/t window, p/t threshold, p/t change; reset 0.
// - sources sharing a pin are ORed onto it.
// - pressure trim is signed 8-bit, 4 Pa per count.
// - temperature trim is signed 8-bit, 0.0625 C per count.
// - altitude trim is signed 8-bit whole meters.
// - altitude trim shifts the reported altitude.
// - only enabled sources reach either pin.
// - pin polarity 0 asserts low (reset), 1 asserts high.
`include "irt_route_trim_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module irt_route_trim #(
   parameter int PRESS_W = `IRT_PRESS_W,
   parameter int TEMP_W  = `IRT_TEMP_W,
   parameter int ALT_W   = `IRT_ALT_W
) (
   input  wire logic                    core_clk,
   input  wire logic                    arst_n,
   input  wire logic [7:0]              reg_addr,
   input  wire logic                    reg_wr,
   input  wire logic [7:0]              reg_wdata,
   output logic      [7:0]              reg_rdata,
   input  wire logic [7:0]              irq_src,
   input  wire logic [7:0]              irq_enable,
   input  wire logic                    first_pin_polarity,
   input  wire logic                    second_pin_polarity,
   output logic                         first_irq_pin,
   output logic                         second_irq_pin,
   input  wire logic [PRESS_W-1:0]      press_comp,
   input  wire logic [TEMP_W-1:0]       temp_comp,
   input  wire logic [ALT_W-1:0]        alt_comp,
   output logic      [PRESS_W-1:0]      press_out,
   output logic      [TEMP_W-1:0]       temp_out,
   output logic      [ALT_W-1:0]        alt_out,
   output logic      [7:0]              route_sel
);

   // the state struct is laid out for the default widths only
   if (PRESS_W != `IRT_PRESS_W || TEMP_W != `IRT_TEMP_W || ALT_W != `IRT_ALT_W)
   begin : g_bad_width
      $error("irt_route_trim: output widths must match the state layout");
   end

   irt_pkg::irt_state_t st_r;
   irt_pkg::irt_state_t st_nxt;

   irt_pin_if pin_first_if ();
   irt_pin_if pin_second_if ();

   assign pin_first_if.src       = irq_src;
   assign pin_first_if.enable    = irq_enable;
   assign pin_first_if.route     = st_r.route;
   assign pin_first_if.polarity  = first_pin_polarity;
   assign pin_second_if.src      = irq_src;
   assign pin_second_if.enable   = irq_enable;
   assign pin_second_if.route    = st_r.route;
   assign pin_second_if.polarity = second_pin_polarity;

   irt_pin_drive #(
      .FIRST_PIN (1'b1)
   ) u_drive_first (
      .pin (pin_first_if.drive)
   );

   irt_pin_drive #(
      .FIRST_PIN (1'b0)
   ) u_drive_second (
      .pin (pin_second_if.drive)
   );

   // sign-extended trims; pressure and altitude shifted left by 4, temperature unscaled
   logic [PRESS_W-1:0] press_trim;
   logic [TEMP_W-1:0]  temp_trim;
   logic [ALT_W-1:0]   alt_trim;

   assign press_trim = {{(PRESS_W-8-`IRT_PRESS_SHIFT){st_r.off_press[7]}},
                        st_r.off_press, {`IRT_PRESS_SHIFT{1'b0}}};
   assign temp_trim  = {{(TEMP_W-8){st_r.off_temp[7]}}, st_r.off_temp};
   assign alt_trim   = {{(ALT_W-8-`IRT_ALT_SHIFT){st_r.off_alt[7]}},
                        st_r.off_alt, {`IRT_ALT_SHIFT{1'b0}}};

   always_comb
   begin
      st_nxt = st_r;
      if (reg_wr)
      begin
         unique case (reg_addr)
            `IRT_OFS_ROUTE:     st_nxt.route     = reg_wdata;
            `IRT_OFS_OFF_PRESS: st_nxt.off_press = reg_wdata;
            `IRT_OFS_OFF_TEMP:  st_nxt.off_temp  = reg_wdata;
            `IRT_OFS_OFF_ALT:   st_nxt.off_alt   = reg_wdata;
            default:            st_nxt.route     = st_r.route;
         endcase
      end
      unique case (reg_addr)
         `IRT_OFS_ROUTE:     st_nxt.rdata = st_r.route;
         `IRT_OFS_OFF_PRESS: st_nxt.rdata = st_r.off_press;
         `IRT_OFS_OFF_TEMP:  st_nxt.rdata = st_r.off_temp;
         `IRT_OFS_OFF_ALT:   st_nxt.rdata = st_r.off_alt;
         default:            st_nxt.rdata = `IRT_RST_UNMAPPED;
      endcase
      st_nxt.pin_first  = pin_first_if.level;
      st_nxt.pin_second = pin_second_if.level;
      st_nxt.press = press_comp + press_trim;
      st_nxt.temp  = temp_comp + temp_trim;
      st_nxt.alt   = alt_comp + alt_trim;
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_r.route      <= `IRT_RST_ROUTE;
         st_r.off_press  <= `IRT_RST_TRIM;
         st_r.off_temp   <= `IRT_RST_TRIM;
         st_r.off_alt    <= `IRT_RST_TRIM;
         st_r.rdata      <= `IRT_RST_UNMAPPED;
         // idle level for the reset polarity (active low)
         st_r.pin_first  <= 1'b1;
         st_r.pin_second <= 1'b1;
         st_r.press      <= '0;
         st_r.temp       <= '0;
         st_r.alt        <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign reg_rdata      = st_r.rdata;
   assign first_irq_pin  = st_r.pin_first;
   assign second_irq_pin = st_r.pin_second;
   assign press_out      = st_r.press;
   assign temp_out       = st_r.temp;
   assign alt_out        = st_r.alt;
   assign route_sel      = st_r.route;

   // assertions
   logic [7:0] first_hits;
   logic [7:0] second_hits;
   assign first_hits  = irq_src & irq_enable & st_r.route;
   assign second_hits = irq_src & irq_enable & ~st_r.route;

   sequence route_written_s;
      reg_wr && reg_addr == `IRT_OFS_ROUTE;
   endsequence

   sequence route_held_s;
      !(reg_wr && reg_addr == `IRT_OFS_ROUTE);
   endsequence

   route_write_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      route_written_s ##1 route_held_s |-> ##1 reg_rdata == $past(reg_wdata, 2)
         || $past(reg_addr) != `IRT_OFS_ROUTE)
      else $error("routing register did not take the written value");

   first_pin_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      arst_n |=> first_irq_pin == ($past(first_pin_polarity) == (|$past(first_hits))))
      else $error("first interrupt pin level wrong");

   second_pin_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      arst_n |=> second_irq_pin == ($past(second_pin_polarity) == (|$past(second_hits))))
      else $error("second interrupt pin level wrong");

   ready_bit_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      (st_r.route[`IRT_BIT_DATA_READY] && irq_enable[`IRT_BIT_DATA_READY]
       && irq_src[`IRT_BIT_DATA_READY] && first_pin_polarity)
      |=> first_irq_pin)
      else $error("data ready source not routed by bit 7");

   disabled_quiet_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      (irq_enable == 8'h00) |=> (first_irq_pin == !$past(first_pin_polarity))
         && (second_irq_pin == !$past(second_pin_polarity)))
      else $error("disabled sources reached a pin");

   press_trim_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      arst_n |=> press_out == 20'($past(press_comp) + 20'($signed($past(st_r.off_press)) * 16)))
      else $error("pressure trim not applied at 4 Pa per count");

   temp_trim_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      arst_n |=> temp_out == 12'($past(temp_comp) + 12'($signed($past(st_r.off_temp)))))
      else $error("temperature trim not applied");

   alt_trim_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      arst_n |=> alt_out == 20'($past(alt_comp) + 20'($signed($past(st_r.off_alt)) * 16)))
      else $error("altitude trim not applied in whole meters");

   unmapped_read_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      (reg_addr < `IRT_OFS_ROUTE || reg_addr > `IRT_OFS_OFF_ALT) |=> reg_rdata == 8'h00)
      else $error("unmapped address did not read zero");

   route_sel_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      arst_n && reg_wr && reg_addr == `IRT_OFS_ROUTE |=> route_sel == $past(reg_wdata))
      else $error("routing register write not seen on route_sel");

   route_keep_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      arst_n && !(reg_wr && reg_addr == `IRT_OFS_ROUTE) |=> $stable(route_sel))
      else $error("routing register changed without a write");

   press_wr_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      arst_n && reg_wr && reg_addr == `IRT_OFS_OFF_PRESS
      |=> st_r.off_press == $past(reg_wdata))
      else $error("pressure trim write lost");

   temp_wr_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      arst_n && reg_wr && reg_addr == `IRT_OFS_OFF_TEMP
      |=> st_r.off_temp == $past(reg_wdata))
      else $error("temperature trim write lost");

   alt_wr_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      arst_n && reg_wr && reg_addr == `IRT_OFS_OFF_ALT
      |=> st_r.off_alt == $past(reg_wdata))
      else $error("altitude trim write lost");

   read_route_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      arst_n && reg_addr == `IRT_OFS_ROUTE |=> reg_rdata == $past(route_sel))
      else $error("routing register read wrong");

   read_press_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      arst_n && reg_addr == `IRT_OFS_OFF_PRESS |=> reg_rdata == $past(st_r.off_press))
      else $error("pressure trim read wrong");

   read_temp_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      arst_n && reg_addr == `IRT_OFS_OFF_TEMP |=> reg_rdata == $past(st_r.off_temp))
      else $error("temperature trim read wrong");

   read_alt_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      arst_n && reg_addr == `IRT_OFS_OFF_ALT |=> reg_rdata == $past(st_r.off_alt))
      else $error("altitude trim read wrong");

   all_first_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      arst_n && st_r.route == 8'hFF
      |=> second_irq_pin == !$past(second_pin_polarity))
      else $error("second pin asserted with every source on the first");

   all_second_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      arst_n && st_r.route == 8'h00
      |=> first_irq_pin == !$past(first_pin_polarity))
      else $error("first pin asserted with every source on the second");

   first_any_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      arst_n && (|first_hits) |=> first_irq_pin == $past(first_pin_polarity))
      else $error("first pin not asserted by a routed source");

   second_any_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      arst_n && (|second_hits) |=> second_irq_pin == $past(second_pin_polarity))
      else $error("second pin not asserted by a routed source");

   fifo_bit_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      (st_r.route[`IRT_BIT_FIFO] && irq_enable[`IRT_BIT_FIFO]
       && irq_src[`IRT_BIT_FIFO] && first_pin_polarity)
      |=> first_irq_pin)
      else $error("fifo source not routed by bit 6");

   tchg_bit_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      (!st_r.route[`IRT_BIT_TEMP_CHG] && irq_enable[`IRT_BIT_TEMP_CHG]
       && irq_src[`IRT_BIT_TEMP_CHG] && second_pin_polarity)
      |=> second_irq_pin)
      else $error("temperature change source not routed by bit 0");

   press_zero_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      arst_n && st_r.off_press == 8'h00 |=> press_out == $past(press_comp))
      else $error("zero pressure trim changed the output");

   temp_zero_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      arst_n && st_r.off_temp == 8'h00 |=> temp_out == $past(temp_comp))
      else $error("zero temperature trim changed the output");

   alt_zero_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      arst_n && st_r.off_alt == 8'h00 |=> alt_out == $past(alt_comp))
      else $error("zero altitude trim changed the output");

   // writes outside the four registers must leave every register alone
   stray_write_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      arst_n && reg_wr && (reg_addr < `IRT_OFS_ROUTE || reg_addr > `IRT_OFS_OFF_ALT)
      |=> $stable(st_r.route) && $stable(st_r.off_press)
          && $stable(st_r.off_temp) && $stable(st_r.off_alt))
      else $error("unmapped write changed a register");

endmodule : irt_route_trim

`default_nettype wire

// file: testbench/irt_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module irt_host_model (
   input  wire logic       core_clk,
   output logic      [7:0] reg_addr,
   output logic            reg_wr,
   output logic      [7:0] reg_wdata,
   input  wire logic [7:0] reg_rdata
);
   initial
   begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
   end

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wr <= 1'b1;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      // data released: show the inverse, not the last value
      reg_wdata <= ~d;
   endtask : wr

   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      @(posedge core_clk);
      @(negedge core_clk);
      d = reg_rdata;
   endtask : rd
endmodule : irt_host_model

`default_nettype wire

// file: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "irt_route_trim_regs.svh"

module tb;
   logic        core_clk, arst_n, reg_wr, pol1, pol2, pin1, pin2;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, src, en, route_sel, rd, r, t;
   logic [19:0] press_comp, alt_comp, press_out, alt_out;
   logic [11:0] temp_comp, temp_out;
   int          error_cnt, tests_run, cyc;

   irt_host_model u_host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

   irt_route_trim u_dut (.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq_src(src),
      .irq_enable(en), .first_pin_polarity(pol1), .second_pin_polarity(pol2),
      .first_irq_pin(pin1), .second_irq_pin(pin2), .press_comp(press_comp),
      .temp_comp(temp_comp), .alt_comp(alt_comp), .press_out(press_out),
      .temp_out(temp_out), .alt_out(alt_out), .route_sel(route_sel));

   task chk(input string name, input logic [19:0] exp, input logic [19:0] got);
      tests_run++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task rchk(input logic [7:0] a, input logic [7:0] exp);
      u_host.rd(a, rd);
      chk("register", {12'h000, exp}, {12'h000, rd});
   endtask : rchk

   task print_verdict;
      $display("errors %0d checks %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : print_verdict

   initial
   begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         error_cnt++;
         print_verdict();
      end
   end

   initial
   begin
      arst_n = 1'b0;
      src = 8'h00;
      en = 8'h00;
      pol1 = 1'b0;
      pol2 = 1'b0;
      press_comp = 20'h12345;
      temp_comp = 12'h9AB;
      alt_comp = 20'h0F0F0;
      repeat (4) @(posedge core_clk);
      arst_n <= 1'b1;
      for (int a = 8'h29; a <= 8'h2E; a++) rchk(8'(a), 8'h00);
      for (int a = 8'h2A; a <= 8'h2E; a++) u_host.wr(8'(a), 8'(a) ^ 8'h5A);
      for (int a = 8'h2A; a <= 8'h2E; a++) rchk(8'(a), (a < 8'h2E) ? 8'(a) ^ 8'h5A : 8'h00);
      for (int m = 0; m < 4; m++)
         for (int i = 0; i < 8; i++)
         begin
            r = m[0] ? ~(8'h01 << i) : (8'h01 << i);
            u_host.wr(`IRT_OFS_ROUTE, r);
            src <= m[1] ? 8'hFF : (8'h01 << i);
            en <= (m == 3) ? ~(8'h01 << i) : 8'hFF;
            pol1 <= m[0];
            pol2 <= m[1];
            @(posedge core_clk);
            @(negedge core_clk);
            chk("route_sel", {12'h000, r}, {12'h000, route_sel});
            chk("first_irq_pin", {19'h0, (|(src & en & r)) ~^ pol1}, {19'h0, pin1});
            chk("second_irq_pin", {19'h0, (|(src & en & ~r)) ~^ pol2}, {19'h0, pin2});
         end
      for (int k = 0; k < 4; k++)
      begin
         t = (k == 0) ? 8'h80 : (k == 1) ? 8'h7F : (k == 2) ? 8'h01 : 8'hFF;
         u_host.wr(`IRT_OFS_OFF_PRESS, t);
         u_host.wr(`IRT_OFS_OFF_TEMP, t);
         u_host.wr(`IRT_OFS_OFF_ALT, t);
         @(posedge core_clk);
         @(negedge core_clk);
         chk("press_out", press_comp + {{8{t[7]}}, t, 4'h0}, press_out);
         chk("temp_out", {8'h00, temp_comp + {{4{t[7]}}, t}}, {8'h00, temp_out});
         chk("alt_out", alt_comp + {{8{t[7]}}, t, 4'h0}, alt_out);
      end
      arst_n <= 1'b0;
      @(negedge core_clk);
      chk("reset pins", 20'h3, {18'h0, pin1, pin2});
      chk("reset press_out", 20'h0, press_out);
      @(posedge core_clk);
      arst_n <= 1'b1;
      for (int a = 8'h2A; a <= 8'h2D; a++) rchk(8'(a), 8'h00);
      @(negedge core_clk);
      chk("alt_out untrimmed", alt_comp, alt_out);
      print_verdict();
   end
endmodule : tb

`default_nettype wire
